// [rtl/ctac_pkg.sv]
// constants and carrier types for the critical temperature alarm compare block
// assumes readings arrive as whole-degree bytes from conversion logic on the same clock
package ctac_pkg;

    // command bytes
    localparam logic [7:0] CMD_MASK_FIRST    = 8'h0C;
    localparam logic [7:0] CMD_MASK_SECOND   = 8'h0D;
    localparam logic [7:0] CMD_MASK_THIRD    = 8'h0E;
    localparam logic [7:0] CMD_DIODE_MODEL   = 8'h30;
    localparam logic [7:0] CMD_BETA_COMP     = 8'h32;
    localparam logic [7:0] CMD_LOCAL_LIMIT   = 8'h40;
    localparam logic [7:0] CMD_R1_T1_LIMIT   = 8'h41;
    localparam logic [7:0] CMD_R2_T1_LIMIT   = 8'h42;
    localparam logic [7:0] CMD_R1_T2_LIMIT   = 8'h49;
    localparam logic [7:0] CMD_R2_T2_LIMIT   = 8'h4A;
    localparam logic [7:0] CMD_ALARM_STATUS  = 8'h50;
    localparam logic [7:0] CMD_HYSTERESIS    = 8'h5A;
    localparam logic [7:0] CMD_MAKER_ID      = 8'hFE;
    localparam logic [7:0] CMD_SILICON_REVISION_IDENTIFIER   = 8'hFF;

    // values after reset
    localparam logic [2:0] RST_MASK_FIRST    = 3'h0;
    localparam logic [2:0] RST_MASK_SECOND   = 3'h0;
    localparam logic [2:0] RST_MASK_THIRD    = 3'h7;
    localparam logic [1:0] RST_DIODE_MODEL   = 2'h0;
    localparam logic [1:0] RST_BETA_COMP     = 2'h0;
    localparam logic [6:0] RST_LOCAL_LIMIT   = 7'h55;
    localparam logic [7:0] RST_TIER1_LIMIT   = 8'h6E;
    localparam logic [7:0] RST_TIER2_LIMIT   = 8'h55;
    localparam logic [4:0] RST_HYSTERESIS    = 5'h0A;

    // field widths and sign bit position
    localparam int HYST_W      = 5;
    localparam int LOCAL_W     = 7;
    localparam int MASK_W      = 3;
    localparam int LOCAL_SIGN  = 7;

    // comparator slots
    localparam int SLOT_LOCAL  = 0;
    localparam int SLOT_R1_T1  = 1;
    localparam int SLOT_R2_T1  = 2;
    localparam int SLOT_R1_T2  = 3;
    localparam int SLOT_R2_T2  = 4;
    localparam int NUM_SLOTS   = 5;

    // readings from the three channels, one byte each
    typedef struct packed {
        logic [7:0] remote_two;
        logic [7:0] remote_one;
        logic [7:0] local_temp;
    } ctac_readings_t;

    // per-output block bits, bit order as in the mask registers
    typedef struct packed {
        logic remote_two_block_bit;
        logic remote_one_block_bit;
        logic local_block_bit;
    } ctac_mask_t;

endpackage

// [rtl/ctac_chan_cmp.sv]
// one channel against one limit with falling-temperature hysteresis
// assumes reading, limit and hysteresis are all on i_core_clk
`timescale 1ns/100ps
module ctac_chan_cmp #(
    parameter int TEMP_W = 8,
    parameter int HYST_W = 5
) (
    input  wire logic              i_core_clk,
    input  wire logic              i_sys_rst,
    input  wire logic [TEMP_W-1:0] i_temp,
    input  wire logic [TEMP_W-1:0] i_limit,
    input  wire logic [HYST_W-1:0] i_hyst,
    output logic                   o_event
);

    logic [TEMP_W:0] lowered_sum;
    logic            next_event;

    // temp + hyst < limit avoids an underflow when hyst exceeds limit
    assign lowered_sum = {1'b0, i_temp} + {{(TEMP_W + 1 - HYST_W){1'b0}}, i_hyst};

    always_comb begin
        next_event = o_event;
        if (!o_event) begin
            if (i_temp > i_limit) begin
                next_event = 1'b1;
            end
        end else if (lowered_sum < {1'b0, i_limit}) begin
            next_event = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_event <= 1'b0;
        end else begin
            o_event <= next_event;
        end
    end

endmodule

// [rtl/ctac_top.sv]
// critical temperature alarm compare: limit, hysteresis, mask and id registers
// and three active-low alarm outputs
// assumes a bus engine delivers decoded command-byte reads and writes as strobes
//
// Summary of operation
// - first alarm judges remotes on first-tier limits, local on the local limit
// - second and third alarms judge remotes on second-tier limits, local on local limit
// - one shared hysteresis lowers every limit, only while temperature falls
// - hysteresis register at command 0x5A, resets to 0x0A
// - hysteresis bits 4..0 unsigned whole degrees, 0 to 31 degrees
// - hysteresis bits 7..5 read-only and read zero
// - per remote input diode model select setting
// - per remote channel beta compensation can be switched off
// - mask bit set blocks that channel's event from that output
// - remote limits unsigned 0..255, first tier reset 0x6E, second 0x55
// - local limit 7 bits, bit 7 reads zero, resets 0x55
`timescale 1ns/100ps
module ctac_top #(
    parameter logic [7:0] MAKER_ID    = 8'h5C, // arbitrary value
    parameter logic [7:0] SILICON_REVISION_IDENTIFIER = 8'h3A  // arbitrary value
) (
    input  wire logic                    i_core_clk,
    input  wire logic                    i_sys_rst,
    input  wire ctac_pkg::ctac_readings_t i_readings,
    input  wire logic [7:0]              i_cmd,
    input  wire logic                    i_wr_stb,
    input  wire logic [7:0]              i_wr_data,
    input  wire logic                    i_rd_stb,
    output logic [7:0]                   o_rd_data,
    output logic                         o_rd_valid,
    output logic                         o_alarm_out_first_n,
    output logic                         o_alarm_out_second_n,
    output logic                         o_alarm_out_third_n,
    output logic [1:0]                   o_diode_model,
    output logic [1:0]                   o_beta_comp_en
);

    ctac_pkg::ctac_mask_t                 mask_first;
    ctac_pkg::ctac_mask_t                 mask_second;
    ctac_pkg::ctac_mask_t                 mask_third;
    logic [ctac_pkg::LOCAL_W-1:0]         local_limit;
    logic [7:0]                           r1_t1_limit;
    logic [7:0]                           r2_t1_limit;
    logic [7:0]                           r1_t2_limit;
    logic [7:0]                           r2_t2_limit;
    logic [ctac_pkg::HYST_W-1:0]          hysteresis;
    logic [7:0]                           slot_temp  [ctac_pkg::NUM_SLOTS];
    logic [7:0]                           slot_limit [ctac_pkg::NUM_SLOTS];
    logic [ctac_pkg::NUM_SLOTS-1:0]       slot_event;
    logic [7:0]                           local_clamped;
    logic [2:0]                           events_first;
    logic [2:0]                           events_tier2;
    logic [7:0]                           next_rd_data;

    // register writes
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            mask_first  <= ctac_pkg::RST_MASK_FIRST;
            mask_second <= ctac_pkg::RST_MASK_SECOND;
            mask_third  <= ctac_pkg::RST_MASK_THIRD;
            local_limit <= ctac_pkg::RST_LOCAL_LIMIT;
            r1_t1_limit <= ctac_pkg::RST_TIER1_LIMIT;
            r2_t1_limit <= ctac_pkg::RST_TIER1_LIMIT;
            r1_t2_limit <= ctac_pkg::RST_TIER2_LIMIT;
            r2_t2_limit <= ctac_pkg::RST_TIER2_LIMIT;
            hysteresis  <= ctac_pkg::RST_HYSTERESIS;
        end else if (i_wr_stb) begin
            if (i_cmd == ctac_pkg::CMD_MASK_FIRST) begin
                mask_first <= i_wr_data[ctac_pkg::MASK_W-1:0];
            end else if (i_cmd == ctac_pkg::CMD_MASK_SECOND) begin
                mask_second <= i_wr_data[ctac_pkg::MASK_W-1:0];
            end else if (i_cmd == ctac_pkg::CMD_MASK_THIRD) begin
                mask_third <= i_wr_data[ctac_pkg::MASK_W-1:0];
            end else if (i_cmd == ctac_pkg::CMD_LOCAL_LIMIT) begin
                local_limit <= i_wr_data[ctac_pkg::LOCAL_W-1:0];
            end else if (i_cmd == ctac_pkg::CMD_R1_T1_LIMIT) begin
                r1_t1_limit <= i_wr_data;
            end else if (i_cmd == ctac_pkg::CMD_R2_T1_LIMIT) begin
                r2_t1_limit <= i_wr_data;
            end else if (i_cmd == ctac_pkg::CMD_R1_T2_LIMIT) begin
                r1_t2_limit <= i_wr_data;
            end else if (i_cmd == ctac_pkg::CMD_R2_T2_LIMIT) begin
                r2_t2_limit <= i_wr_data;
            end else if (i_cmd == ctac_pkg::CMD_HYSTERESIS) begin
                hysteresis <= i_wr_data[ctac_pkg::HYST_W-1:0];
            end
        end
    end

    // analog front-end settings, bit 0 remote one, bit 1 remote two
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_diode_model  <= ctac_pkg::RST_DIODE_MODEL;
            o_beta_comp_en <= ctac_pkg::RST_BETA_COMP;
        end else if (i_wr_stb) begin
            if (i_cmd == ctac_pkg::CMD_DIODE_MODEL) begin
                o_diode_model <= i_wr_data[1:0];
            end else if (i_cmd == ctac_pkg::CMD_BETA_COMP) begin
                o_beta_comp_en <= i_wr_data[1:0];
            end
        end
    end

    // register reads; unused and read-only bits return zero
    always_comb begin
        next_rd_data = 8'h00;
        if (i_cmd == ctac_pkg::CMD_MASK_FIRST) begin
            next_rd_data = {5'h00, mask_first};
        end else if (i_cmd == ctac_pkg::CMD_MASK_SECOND) begin
            next_rd_data = {5'h00, mask_second};
        end else if (i_cmd == ctac_pkg::CMD_MASK_THIRD) begin
            next_rd_data = {5'h00, mask_third};
        end else if (i_cmd == ctac_pkg::CMD_DIODE_MODEL) begin
            next_rd_data = {6'h00, o_diode_model};
        end else if (i_cmd == ctac_pkg::CMD_BETA_COMP) begin
            next_rd_data = {6'h00, o_beta_comp_en};
        end else if (i_cmd == ctac_pkg::CMD_LOCAL_LIMIT) begin
            next_rd_data = {1'b0, local_limit};
        end else if (i_cmd == ctac_pkg::CMD_R1_T1_LIMIT) begin
            next_rd_data = r1_t1_limit;
        end else if (i_cmd == ctac_pkg::CMD_R2_T1_LIMIT) begin
            next_rd_data = r2_t1_limit;
        end else if (i_cmd == ctac_pkg::CMD_R1_T2_LIMIT) begin
            next_rd_data = r1_t2_limit;
        end else if (i_cmd == ctac_pkg::CMD_R2_T2_LIMIT) begin
            next_rd_data = r2_t2_limit;
        end else if (i_cmd == ctac_pkg::CMD_ALARM_STATUS) begin
            next_rd_data = {5'h00, ~o_alarm_out_third_n, ~o_alarm_out_second_n,
                            ~o_alarm_out_first_n};
        end else if (i_cmd == ctac_pkg::CMD_HYSTERESIS) begin
            next_rd_data = {3'h0, hysteresis};
        end else if (i_cmd == ctac_pkg::CMD_MAKER_ID) begin
            next_rd_data = MAKER_ID;
        end else if (i_cmd == ctac_pkg::CMD_SILICON_REVISION_IDENTIFIER) begin
            next_rd_data = SILICON_REVISION_IDENTIFIER;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_rd_data  <= 8'h00;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= i_rd_stb;
            if (i_rd_stb) begin
                o_rd_data <= next_rd_data;
            end
        end
    end

    // a negative local reading can never exceed a 0..127 limit, so clamp it to zero
    assign local_clamped = i_readings.local_temp[ctac_pkg::LOCAL_SIGN] ? 8'h00
                                                                       : i_readings.local_temp;

    // one local comparator serves all three outputs since they share the local limit
    always_comb begin
        slot_temp[ctac_pkg::SLOT_LOCAL]  = local_clamped;
        slot_limit[ctac_pkg::SLOT_LOCAL] = {1'b0, local_limit};
        slot_temp[ctac_pkg::SLOT_R1_T1]  = i_readings.remote_one;
        slot_limit[ctac_pkg::SLOT_R1_T1] = r1_t1_limit;
        slot_temp[ctac_pkg::SLOT_R2_T1]  = i_readings.remote_two;
        slot_limit[ctac_pkg::SLOT_R2_T1] = r2_t1_limit;
        slot_temp[ctac_pkg::SLOT_R1_T2]  = i_readings.remote_one;
        slot_limit[ctac_pkg::SLOT_R1_T2] = r1_t2_limit;
        slot_temp[ctac_pkg::SLOT_R2_T2]  = i_readings.remote_two;
        slot_limit[ctac_pkg::SLOT_R2_T2] = r2_t2_limit;
    end

    for (genvar s = 0; s < ctac_pkg::NUM_SLOTS; s++) begin : g_slot
        ctac_chan_cmp #(
            .TEMP_W (8),
            .HYST_W (ctac_pkg::HYST_W)
        ) u_cmp (
            .i_core_clk (i_core_clk),
            .i_sys_rst  (i_sys_rst),
            .i_temp     (slot_temp[s]),
            .i_limit    (slot_limit[s]),
            .i_hyst     (hysteresis),
            .o_event    (slot_event[s])
        );
    end

    assign events_first = {slot_event[ctac_pkg::SLOT_R2_T1], slot_event[ctac_pkg::SLOT_R1_T1],
                           slot_event[ctac_pkg::SLOT_LOCAL]};
    assign events_tier2 = {slot_event[ctac_pkg::SLOT_R2_T2], slot_event[ctac_pkg::SLOT_R1_T2],
                           slot_event[ctac_pkg::SLOT_LOCAL]};

    // alarm pins, low while any unmasked event is active
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_alarm_out_first_n  <= 1'b1;
            o_alarm_out_second_n <= 1'b1;
            o_alarm_out_third_n  <= 1'b1;
        end else begin
            o_alarm_out_first_n  <= ~|(events_first & ~mask_first);
            o_alarm_out_second_n <= ~|(events_tier2 & ~mask_second);
            o_alarm_out_third_n  <= ~|(events_tier2 & ~mask_third);
        end
    end

endmodule

// [tb/ctac_chk.sv]
// port-level assertions for the alarm compare top
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/100ps
module ctac_chk #(
    parameter logic [7:0] MAKER_ID    = 8'h5C,
    parameter logic [7:0] SILICON_REVISION_IDENTIFIER = 8'h3A
) (
    input wire logic                     i_core_clk,
    input wire logic                     i_sys_rst,
    input wire ctac_pkg::ctac_readings_t i_readings,
    input wire logic [7:0]               i_cmd,
    input wire logic                     i_wr_stb,
    input wire logic [7:0]               i_wr_data,
    input wire logic                     i_rd_stb,
    input wire logic [7:0]               o_rd_data,
    input wire logic                     o_rd_valid,
    input wire logic                     o_alarm_out_first_n,
    input wire logic                     o_alarm_out_second_n,
    input wire logic                     o_alarm_out_third_n,
    input wire logic [1:0]               o_diode_model,
    input wire logic [1:0]               o_beta_comp_en
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    sequence s_rd(logic [7:0] c);
        i_rd_stb && (i_cmd == c);
    endsequence
    property p_rd_valid; i_rd_stb |=> o_rd_valid; endproperty
    property p_no_valid; !i_rd_stb |=> !o_rd_valid; endproperty
    property p_hold; !i_rd_stb |=> $stable(o_rd_data); endproperty
    property p_hyst_hi; s_rd(ctac_pkg::CMD_HYSTERESIS) |=> o_rd_data[7:5] == 3'h0; endproperty
    property p_local_hi; s_rd(ctac_pkg::CMD_LOCAL_LIMIT) |=> !o_rd_data[7]; endproperty
    property p_mask_hi;
        (s_rd(ctac_pkg::CMD_MASK_SECOND) or s_rd(ctac_pkg::CMD_MASK_THIRD))
            |=> o_rd_data[7:3] == 5'h00;
    endproperty
    property p_model_hi; s_rd(ctac_pkg::CMD_DIODE_MODEL) |=> o_rd_data[7:2] == 6'h00; endproperty
    property p_maker; s_rd(ctac_pkg::CMD_MAKER_ID) |=> o_rd_data == MAKER_ID; endproperty
    property p_rev; s_rd(ctac_pkg::CMD_SILICON_REVISION_IDENTIFIER) |=> o_rd_data == SILICON_REVISION_IDENTIFIER; endproperty
    // reset must quiet the pins even though the default disable hides it
    property p_rst_quiet;
        disable iff (1'b0) i_sys_rst |=> o_alarm_out_first_n && o_alarm_out_second_n
            && o_alarm_out_third_n && !o_rd_valid;
    endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
    a_no_valid: assert property (p_no_valid) else $error("stray read valid");
    a_hold: assert property (p_hold) else $error("read data moved");
    a_hyst_hi: assert property (p_hyst_hi) else $error("hysteresis top bits set");
    a_local_hi: assert property (p_local_hi) else $error("local limit bit 7 set");
    a_mask_hi: assert property (p_mask_hi) else $error("mask top bits set");
    a_model_hi: assert property (p_model_hi) else $error("model top bits set");
    a_maker: assert property (p_maker) else $error("maker id wrong");
    a_rev: assert property (p_rev) else $error("silicon_revision_identifier wrong");
    a_rst_quiet: assert property (p_rst_quiet) else $error("pins active in reset");
endmodule
bind ctac_top ctac_chk #(.MAKER_ID(MAKER_ID), .SILICON_REVISION_IDENTIFIER(SILICON_REVISION_IDENTIFIER)) u_chk (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_readings(i_readings),
    .i_cmd(i_cmd), .i_wr_stb(i_wr_stb), .i_wr_data(i_wr_data), .i_rd_stb(i_rd_stb),
    .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
    .o_alarm_out_first_n(o_alarm_out_first_n), .o_alarm_out_second_n(o_alarm_out_second_n),
    .o_alarm_out_third_n(o_alarm_out_third_n), .o_diode_model(o_diode_model),
    .o_beta_comp_en(o_beta_comp_en));

// [tb/ctac_host.sv]
// host model: byte writes and reads addressed by command byte
// assumes tasks are entered just after a rising edge
`timescale 1ns/100ps
module ctac_host (
    input  wire logic       i_core_clk,
    input  wire logic [7:0] i_rd_data,
    input  wire logic       i_rd_valid,
    output logic [7:0]      o_cmd,
    output logic            o_wr_stb,
    output logic [7:0]      o_wr_data,
    output logic            o_rd_stb
);
    initial begin
        o_cmd = 8'h00;
        o_wr_stb = 1'b0;
        o_wr_data = 8'h00;
        o_rd_stb = 1'b0;
    end
    // gap idles first so slow hosts are covered; idle lines show inverted values
    task automatic wr(input logic [7:0] c, input logic [7:0] d, input int gap);
        repeat (gap) @(posedge i_core_clk);
        if (gap > 0) #1;
        o_cmd = c;
        o_wr_data = d;
        o_wr_stb = 1'b1;
        @(posedge i_core_clk);
        #1 o_wr_stb = 1'b0;
        o_cmd = ~c;
        o_wr_data = ~d;
        // one idle edge so a following request never re-raises a strobe in the same step
        @(posedge i_core_clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] c, output logic [7:0] d, output logic v);
        o_cmd = c;
        o_rd_stb = 1'b1;
        @(posedge i_core_clk);
        #1 o_rd_stb = 1'b0;
        o_cmd = ~c;
        v = i_rd_valid;
        d = i_rd_data;
        @(posedge i_core_clk);
        #1;
    endtask
endmodule

// [tb/critical_temp_alarm_compare_tb.sv]
// self-checking bench for the alarm compare top
// assumes the host model drives the register port
`timescale 1ns/100ps
module critical_temp_alarm_compare_tb;
    logic                     clk = 1'b0;
    logic                     rst = 1'b1;
    ctac_pkg::ctac_readings_t rdg = '0;
    logic [7:0]               cmd, wd, rdd, d;
    logic                     ws, rs, rv, a1, a2, a3, v;
    logic [1:0]               dm, bc;
    int                       n_fail = 0;
    int                       cmp_count = 0;
    int                       cyc = 0;
    // {command, reset value, write value, read back}
    logic [31:0] rows [15] = '{32'h0C00FF07, 32'h0D000000, 32'h0E070000, 32'h4055FF7F,
        32'h416EABAB, 32'h426E6E6E, 32'h4955FFFF, 32'h4A554040, 32'h5A0AFF1F,
        32'h3000FF03, 32'h3200FF03, 32'hFE5C005C, 32'hFF3A123A, 32'h5000FF00, 32'h7700FF00};
    always #5 clk = ~clk;
    ctac_top dut (.i_core_clk(clk), .i_sys_rst(rst), .i_readings(rdg), .i_cmd(cmd),
        .i_wr_stb(ws), .i_wr_data(wd), .i_rd_stb(rs), .o_rd_data(rdd), .o_rd_valid(rv),
        .o_alarm_out_first_n(a1), .o_alarm_out_second_n(a2), .o_alarm_out_third_n(a3),
        .o_diode_model(dm), .o_beta_comp_en(bc));
    ctac_host host (.i_core_clk(clk), .i_rd_data(rdd), .i_rd_valid(rv), .o_cmd(cmd),
        .o_wr_stb(ws), .o_wr_data(wd), .o_rd_stb(rs));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] c, input logic [7:0] e);
        host.rd(c, d, v);
        chk(v, 8'h01);
        chk(d, e);
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ceiling well above the roughly 154 cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial begin
        step(12);
        rst = 1'b0;
        step(1);
        foreach (rows[i]) begin
            rdchk(rows[i][31:24], rows[i][23:16]);
            host.wr(rows[i][31:24], rows[i][15:8], i % 2);
            rdchk(rows[i][31:24], rows[i][7:0]);
        end
        chk(dm, 8'h03);
        chk(bc, 8'h03);
        $display("register table done");
        host.wr(8'h0C, 8'h00, 0);
        host.wr(8'h41, 8'h6E, 0);
        host.wr(8'h5A, 8'h0A, 0);
        rdg.remote_one = 8'h6E;
        step(3);
        chk(a1, 8'h01);
        rdg.remote_one = 8'h6F;
        step(3);
        chk({a1, a2}, 8'h01);
        rdchk(8'h50, 8'h01);
        rdg.remote_one = 8'h64;
        step(3);
        chk(a1, 8'h00);
        rdg.remote_one = 8'h63;
        step(3);
        chk(a1, 8'h01);
        $display("first pin hysteresis done");
        rdg.remote_two = 8'h41;
        step(3);
        chk({a1, a2, a3}, 8'h04);
        host.wr(8'h0E, 8'h04, 0);
        step(2);
        chk({a1, a2, a3}, 8'h05);
        host.wr(8'h40, 8'h20, 0);
        rdg.remote_two = 8'h00;
        rdg.local_temp = 8'h21;
        step(3);
        chk({a1, a2, a3}, 8'h00);
        rdg.local_temp = 8'h90;
        step(3);
        chk({a1, a2, a3}, 8'h07);
        $display("tier and mask done");
        rdg.local_temp = 8'h21;
        step(3);
        rst = 1'b1;
        step(1);
        chk({a1, a2, a3}, 8'h07);
        rst = 1'b0;
        step(1);
        rdchk(8'h5A, 8'h0A);
        rdchk(8'h40, 8'h55);
        $display("mid-run reset done");
        tally_and_finish();
    end
endmodule
